// ==== pmx_map.vh ====
// Purpose: Offsets, field positions, reset values and timing constants
//          of the power-management and window-0 register bank.
// Assumes: Included once per file by its bare name.
// Notes:   Definitions only.
`ifndef PMX_MAP_VH
`define PMX_MAP_VH
// ==========================================================
// Register byte offsets.
`define PMX_OFS_PMCS      8'h94
`define PMX_OFS_XBASE     8'h98
`define PMX_OFS_SETUP     8'h9c
`define PMX_OFS_IRQ_STAT  8'hb0
`define PMX_OFS_IRQ_MASK  8'hb4
// ==========================================================
// Power-management control/status fields.
`define PMX_PS_HI         1
`define PMX_PS_LO         0
`define PMX_PS_D0         2'h0
`define PMX_PS_D1         2'h1
`define PMX_PS_D2         2'h2
`define PMX_PS_D3         2'h3
`define PMX_PME_EN_BIT    8
`define PMX_PME_STS_BIT   15
`define PMX_PS_RST        2'h0
// ==========================================================
// Window-0 translated base and setup fields.
`define PMX_XB_HI         31
`define PMX_XB_LO         12
`define PMX_XB_RST        20'h00000
`define PMX_SU_TYPE_BIT   0
`define PMX_SU_AW_HI      2
`define PMX_SU_AW_LO      1
`define PMX_SU_PF_BIT     3
`define PMX_SU_MSK_HI     30
`define PMX_SU_MSK_LO     12
`define PMX_SU_EN_BIT     31
`define PMX_SU_AW_RST     2'h0
`define PMX_SU_MSK_RST    19'h7ffff
// ==========================================================
// Interrupt status bits.
`define PMX_IRQ_W         3
`define PMX_IRQ_PME       0
`define PMX_IRQ_WAKE      1
`define PMX_IRQ_BADPS     2
// ==========================================================
// Timing: internal reset length in ns and the clock period in ns.
`define PMX_FRST_NS       64
`define PMX_CLK_NS        4
`define PMX_FRST_CW       5
`endif

// ==== pmx_sync2.v ====
// Purpose: Two-flop synchroniser for a level from outside the clock domain.
// Assumes: Single-bit level; pulse shorter than two clocks may be lost.
// Notes:   First flop feeds only the second flop.
`timescale 1ns/1ps
module pmx_sync2 (
   input  wire clk_sys_i,
   input  wire rst_n_i,
   input  wire async_i,
   output wire sync_o
);
   reg meta_q;
   reg sync_q;

   // ==========================================================
   // Synchroniser chain, reset to the inactive level.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;
endmodule

// ==== pmx_csr_top.v ====
// Purpose: Power-management control/status word and downstream window-0
//          translation registers, reached over classic Wishbone.
// Assumes: One 250 MHz clock; asynchronous active-low reset.
// Notes:   Sticky bits survive the internal D3-to-D0 reset.
`timescale 1ns/1ps
`include "pmx_map.vh"
module pmx_csr_top (
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   // Wishbone classic slave.
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire        wb_ack_o,
   // Setup loader path, same clock domain.
   input  wire        setup_ld_i,
   input  wire [31:0] setup_ld_dat_i,
   // Wake event from a pin, asynchronous.
   input  wire        wake_evt_i,
   // Window-0 translation request, same clock domain.
   input  wire        xl_req_i,
   input  wire [31:0] xl_addr_i,
   output wire        xl_vld_o,
   output wire [31:0] xl_addr_o,
   // Outputs.
   output wire [1:0]  power_state_o,
   output wire        func_rst_o,
   output wire        power_event_out_n_o,
   output wire        irq_o
);
   // ==========================================================
   // Internal reset length in clock cycles, rounded up. The integer
   // result is cut to the counter width on purpose; the counter width
   // must cover the count or the reset would come out short.
   localparam integer FRST_CYC_N =
      (`PMX_FRST_NS + `PMX_CLK_NS - 1) / `PMX_CLK_NS;
   localparam [`PMX_FRST_CW-1:0] FRST_CYC = FRST_CYC_N[`PMX_FRST_CW-1:0];
   localparam [`PMX_FRST_CW-1:0] FRST_ONE =
      {{(`PMX_FRST_CW-1){1'b0}}, 1'b1};

   // ==========================================================
   // Helper functions.
   // Byte-lane write merge shared by the power word and the translated base.
   function [31:0] lane_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer      i;
      begin
         lane_merge = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               lane_merge[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   // Only D0 and D3 are implemented encodings.
   function ps_valid;
      input [1:0] ps;
      begin
         ps_valid = (ps == `PMX_PS_D0) || (ps == `PMX_PS_D3);
      end
   endfunction

   // Write strobe of one register lane on the edge where ack is seen.
   function wr_hit;
      input       wr;
      input [7:0] adr;
      input [7:0] ofs;
      input       lane;
      begin
         wr_hit = wr && (adr == ofs) && lane;
      end
   endfunction

   // ==========================================================
   // State.
   reg                    ack_q;
   reg [31:0]             rdat_q;
   reg [1:0]              ps_q;
   reg                    pme_en_q;
   reg                    pme_sts_q;
   reg [19:0]             xbase_q;
   reg [1:0]              su_aw_q;
   reg                    su_pf_q;
   reg [18:0]             su_msk_q;
   reg [`PMX_FRST_CW-1:0] frst_cnt_q;
   reg                    wake_d_q;
   reg [`PMX_IRQ_W-1:0]   irq_sts_q;
   reg [`PMX_IRQ_W-1:0]   irq_msk_q;
   reg                    xl_vld_q;
   reg [31:0]             xl_addr_q;

   wire                   wake_s;
   wire                   req;
   wire                   wr_now;
   wire                   rd_now;
   wire                   frst;
   wire                   wake_rise;
   reg  [31:0]            pmcs_rd;
   reg  [31:0]            xbase_rd;
   reg  [31:0]            setup_rd;
   reg  [31:0]            rd_mux;
   reg  [31:0]            pmcs_wr;
   reg  [31:0]            xbase_wr;
   reg                    ps_wr_ok;
   reg                    ps_wr_bad;
   reg                    wake_go;
   wire [19:0]            xl_msk;
   wire                   we_pmcs_lo;
   wire                   we_pmcs_hi;
   wire                   we_xbase;
   wire                   we_irq_sts;
   wire                   we_irq_msk;

   // ==========================================================
   // Wake pin passes the synchroniser before any logic reads it.
   pmx_sync2 u_wake_sync (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .async_i   (wake_evt_i),
      .sync_o    (wake_s)
   );

   assign wake_rise = wake_s & ~wake_d_q;

   // ==========================================================
   // Bus decode. Ack comes one cycle after the request is seen and
   // the write lands on the edge at which the master samples ack.
   assign req    = wb_cyc_i & wb_stb_i;
   assign wr_now = req & ack_q & wb_we_i;
   assign rd_now = req & ~ack_q;
   assign frst   = (frst_cnt_q != {`PMX_FRST_CW{1'b0}});

   // Per-register write strobes. The power word needs lane 0 for the
   // state field and lane 1 for the event bits. The translated base
   // is merged lane by lane, so any lane qualifies its write.
   assign we_pmcs_lo = wr_hit(wr_now, wb_adr_i, `PMX_OFS_PMCS, wb_sel_i[0]);
   assign we_pmcs_hi = wr_hit(wr_now, wb_adr_i, `PMX_OFS_PMCS, wb_sel_i[1]);
   assign we_xbase   = wr_hit(wr_now, wb_adr_i, `PMX_OFS_XBASE, 1'b1);
   assign we_irq_sts = wr_hit(wr_now, wb_adr_i, `PMX_OFS_IRQ_STAT,
                              wb_sel_i[0]);
   assign we_irq_msk = wr_hit(wr_now, wb_adr_i, `PMX_OFS_IRQ_MASK,
                              wb_sel_i[0]);

   // ==========================================================
   // Read views of each register.
   always @* begin
      pmcs_rd = 32'h00000000;
      pmcs_rd[`PMX_PS_HI:`PMX_PS_LO] = ps_q;
      pmcs_rd[`PMX_PME_EN_BIT]  = pme_en_q;
      pmcs_rd[`PMX_PME_STS_BIT] = pme_sts_q;
      xbase_rd = 32'h00000000;
      xbase_rd[`PMX_XB_HI:`PMX_XB_LO] = xbase_q;
      setup_rd = 32'h00000000;
      setup_rd[`PMX_SU_TYPE_BIT] = 1'b0;
      setup_rd[`PMX_SU_AW_HI:`PMX_SU_AW_LO] = su_aw_q;
      setup_rd[`PMX_SU_PF_BIT] = su_pf_q;
      setup_rd[`PMX_SU_MSK_HI:`PMX_SU_MSK_LO] = su_msk_q;
      setup_rd[`PMX_SU_EN_BIT] = 1'b1;
   end

   // Read multiplexer; unmapped offsets read as zero.
   always @* begin
      case (wb_adr_i)
         `PMX_OFS_PMCS:     rd_mux = pmcs_rd;
         `PMX_OFS_XBASE:    rd_mux = xbase_rd;
         `PMX_OFS_SETUP:    rd_mux = setup_rd;
         `PMX_OFS_IRQ_STAT: rd_mux = {29'h0, irq_sts_q};
         `PMX_OFS_IRQ_MASK: rd_mux = {29'h0, irq_msk_q};
         default:           rd_mux = 32'h00000000;
      endcase
   end

   // ==========================================================
   // Write decode for the power word. Invalid state codes leave the
   // stored state alone but the other lanes still take effect.
   always @* begin
      pmcs_wr   = lane_merge(pmcs_rd, wb_dat_i, wb_sel_i);
      xbase_wr  = lane_merge(xbase_rd, wb_dat_i, wb_sel_i);
      ps_wr_ok  = 1'b0;
      ps_wr_bad = 1'b0;
      wake_go   = 1'b0;
      if (we_pmcs_lo) begin
         if (ps_valid(pmcs_wr[`PMX_PS_HI:`PMX_PS_LO])) begin
            ps_wr_ok = 1'b1;
         end else begin
            ps_wr_bad = 1'b1;
         end
         wake_go = ps_wr_ok && (ps_q == `PMX_PS_D3) &&
                   (pmcs_wr[`PMX_PS_HI:`PMX_PS_LO] == `PMX_PS_D0);
      end
   end

   // ==========================================================
   // Bus handshake and registered read data.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ack_q  <= 1'b0;
         rdat_q <= 32'h00000000;
      end else begin
         ack_q <= rd_now;
         if (rd_now) begin
            rdat_q <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Power state. Cleared again by the internal reset so that the
   // block leaves its wake-up sequence in D0.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ps_q <= `PMX_PS_RST;
      end else if (frst) begin
         ps_q <= `PMX_PS_RST;
      end else if (ps_wr_ok) begin
         ps_q <= pmcs_wr[`PMX_PS_HI:`PMX_PS_LO];
      end
   end

   // Internal reset counter. Only the core is reset; the secondary
   // bus reset pin is not touched, so no such output exists here.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         frst_cnt_q <= {`PMX_FRST_CW{1'b0}};
      end else if (wake_go) begin
         frst_cnt_q <= FRST_CYC;
      end else if (frst) begin
         frst_cnt_q <= frst_cnt_q - FRST_ONE;
      end
   end

   // ==========================================================
   // Sticky power-event bits: reset only by the device reset.
   // A wake edge in the clearing cycle keeps the status set.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pme_en_q  <= 1'b0;
         pme_sts_q <= 1'b0;
         wake_d_q  <= 1'b0;
      end else begin
         wake_d_q <= wake_s;
         if (we_pmcs_hi) begin
            pme_en_q <= wb_dat_i[`PMX_PME_EN_BIT];
         end
         if (wake_rise) begin
            pme_sts_q <= 1'b1;
         end else if (we_pmcs_hi && wb_dat_i[`PMX_PME_STS_BIT]) begin
            pme_sts_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Translated base: bus writable, cleared by the internal reset.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xbase_q <= `PMX_XB_RST;
      end else if (frst) begin
         xbase_q <= `PMX_XB_RST;
      end else if (we_xbase) begin
         xbase_q <= xbase_wr[`PMX_XB_HI:`PMX_XB_LO];
      end
   end

   // Setup fields: bus writes are ignored, only the loader path can
   // change them. The enable bit has no storage and reads one.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         su_aw_q  <= `PMX_SU_AW_RST;
         su_pf_q  <= 1'b0;
         su_msk_q <= `PMX_SU_MSK_RST;
      end else if (setup_ld_i) begin
         su_aw_q  <= setup_ld_dat_i[`PMX_SU_AW_HI:`PMX_SU_AW_LO];
         su_pf_q  <= setup_ld_dat_i[`PMX_SU_PF_BIT];
         su_msk_q <= setup_ld_dat_i[`PMX_SU_MSK_HI:`PMX_SU_MSK_LO];
      end
   end

   // ==========================================================
   // Window-0 translation: mask bits pick the translated base, the
   // rest of the address passes through. Bit 31 is always taken
   // from the base because the window enable is stuck at one.
   assign xl_msk = {1'b1, su_msk_q};

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         xl_vld_q  <= 1'b0;
         xl_addr_q <= 32'h00000000;
      end else begin
         xl_vld_q <= xl_req_i;
         if (xl_req_i) begin
            xl_addr_q <= {(xbase_q & xl_msk) |
                          (xl_addr_i[`PMX_XB_HI:`PMX_XB_LO] & ~xl_msk),
                          xl_addr_i[`PMX_XB_LO-1:0]};
         end
      end
   end

   // ==========================================================
   // Interrupt status, write one to clear; new events win.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         irq_sts_q <= {`PMX_IRQ_W{1'b0}};
         irq_msk_q <= {`PMX_IRQ_W{1'b0}};
      end else begin
         if (we_irq_msk) begin
            irq_msk_q <= wb_dat_i[`PMX_IRQ_W-1:0];
         end
         irq_sts_q <= (irq_sts_q &
            ~(we_irq_sts ? wb_dat_i[`PMX_IRQ_W-1:0] : {`PMX_IRQ_W{1'b0}}))
            | {ps_wr_bad, wake_go, wake_rise};
      end
   end

   // ==========================================================
   // Outputs. The event pin is low only while enabled and pending.
   assign wb_ack_o            = ack_q;
   assign wb_dat_o            = rdat_q;
   assign xl_vld_o            = xl_vld_q;
   assign xl_addr_o           = xl_addr_q;
   assign power_state_o       = ps_q;
   assign func_rst_o          = frst;
   assign power_event_out_n_o = ~(pme_en_q & pme_sts_q);
   assign irq_o               = |(irq_sts_q & irq_msk_q);
endmodule

// ==== pmx_csr_top_chk.sv ====
// Purpose: Port-level assertions for the power-management register bank.
// Assumes: One clock domain with an asynchronous active-low reset.
// Notes:   Attached to every instance of the top module by the bind below.
`timescale 1ns/1ps
module pmx_csr_top_chk (
   input wire        clk_sys_i,
   input wire        rst_n_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        xl_req_i,
   input wire [31:0] xl_addr_i,
   input wire        xl_vld_o,
   input wire [31:0] xl_addr_o,
   input wire [1:0]  power_state_o,
   input wire        func_rst_o
);
   // ==========================================================
   // Helper logic
   // Accepted accesses are qualified by ack, since writes land on that edge.
   wire       wr_ack = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i;
   wire       rd_ack = wb_ack_o && wb_cyc_i && wb_stb_i && !wb_we_i;
   wire       ps_wr  = wr_ack && wb_adr_i == 8'h94 && wb_sel_i[0];
   wire [1:0] wps    = wb_dat_i[1:0];
   wire [11:0] xl_lo = xl_addr_i[11:0];
   logic [5:0] frst_cnt_q;

   // The pulse is too long for a repetition, so its length is counted.
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i)
         frst_cnt_q <= 6'd0;
      else if (func_rst_o)
         frst_cnt_q <= frst_cnt_q + 6'd1;
      else
         frst_cnt_q <= 6'd0;
   end

   // ==========================================================
   // Assertions
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);

   chk_ps_write: assert property (
      ps_wr && wps != 2'h1 && wps != 2'h2 && !func_rst_o
      |=> power_state_o == $past(wps)) else $error("state write lost.");
   chk_ps_ignore: assert property (
      ps_wr && (wps == 2'h1 || wps == 2'h2) |=> $stable(power_state_o))
      else $error("unsupported state was stored.");
   chk_frst_start: assert property (
      ps_wr && wps == 2'h0 && power_state_o == 2'h3 |-> ##[1:3] func_rst_o)
      else $error("no internal reset on wake.");
   chk_frst_len: assert property (
      $fell(func_rst_o) |-> frst_cnt_q == 6'd16)
      else $error("internal reset length wrong.");
   chk_frst_max: assert property (frst_cnt_q <= 6'd16)
      else $error("internal reset too long.");
   chk_pm_zero: assert property (
      rd_ack && wb_adr_i == 8'h94 |-> (wb_dat_o & 32'hffff7efc) == 32'h0)
      else $error("reserved status bits not zero.");
   chk_xb_low: assert property (
      rd_ack && wb_adr_i == 8'h98 |-> wb_dat_o[11:0] == 12'h000)
      else $error("low base bits not zero.");
   chk_setup_fix: assert property (
      rd_ack && wb_adr_i == 8'h9c
      |-> wb_dat_o[31] && !wb_dat_o[0] && wb_dat_o[11:4] == 8'h00)
      else $error("fixed setup bits wrong.");
   // Low twelve bits always pass straight through the window.
   chk_xl_low: assert property (
      xl_req_i |=> xl_vld_o && xl_addr_o[11:0] == $past(xl_lo))
      else $error("translation answer wrong.");
   cov_bad_state: cover property (ps_wr && wps == 2'h2);
   cov_wake_rst: cover property ($fell(func_rst_o));
   cov_xl: cover property (xl_req_i ##1 xl_req_i);
endmodule

bind pmx_csr_top pmx_csr_top_chk u_chk (.*);

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the power-management register bank.
// Assumes: 250 MHz clock; reset held for eight cycles at the start.
// Notes:   Register cases sit in a table; wake, loader and irq follow.
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic        setup_ld_i = 1'b0;
   logic [31:0] setup_ld_dat_i = 32'h0;
   logic        wake_evt_i = 1'b0;
   logic        xl_req_i = 1'b0;
   logic [31:0] xl_addr_i = 32'h0;
   wire [31:0]  wb_dat_o;
   wire         wb_ack_o;
   wire         xl_vld_o;
   wire [31:0]  xl_addr_o;
   wire [1:0]   power_state_o;
   wire         func_rst_o;
   wire         power_event_out_n_o;
   wire         irq_o;
   int          errors = 0;
   int          checked = 0;
   int          frst_cycles = 0;
   logic [31:0] rd;
   typedef struct {logic we; logic [7:0] a; logic [3:0] s; logic [31:0] d;}
      pmx_row_t;
   // Reads carry the expected word in d; writes carry the data.
   pmx_row_t rows[15] = '{
      '{0, 8'h94, 4'hf, 32'h0}, '{0, 8'h98, 4'hf, 32'h0},
      '{0, 8'h9c, 4'hf, 32'hfffff000}, '{1, 8'h94, 4'hf, 32'hffffffff},
      '{0, 8'h94, 4'hf, 32'h00000103}, '{1, 8'h94, 4'h1, 32'h1},
      '{0, 8'h94, 4'hf, 32'h00000103}, '{1, 8'h94, 4'h1, 32'h2},
      '{0, 8'h94, 4'hf, 32'h00000103}, '{1, 8'h98, 4'hf, 32'hffffffff},
      '{0, 8'h98, 4'hf, 32'hfffff000}, '{1, 8'h9c, 4'hf, 32'h0},
      '{0, 8'h9c, 4'hf, 32'hfffff000}, '{1, 8'h40, 4'hf, 32'hffffffff},
      '{0, 8'h40, 4'hf, 32'h0}};

   pmx_csr_top u_dut (.*);

   // ==========================================================
   // Clock and reset-pulse counting
   always #2 clk_sys_i = ~clk_sys_i;
   always @(posedge clk_sys_i) if (func_rst_o === 1'b1) frst_cycles++;

   // ==========================================================
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Classic cycle; ack and read data are taken at the rising edge at
   // which ack is sampled high, and only then is the request dropped.
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [3:0] s, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= d;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) errors++;
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic xl(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk_sys_i);
      xl_req_i <= 1'b1;
      xl_addr_i <= a;
      @(posedge clk_sys_i);
      xl_req_i <= 1'b0;
      @(negedge clk_sys_i);
      chk({31'h0, xl_vld_o}, 32'h1);
      chk(xl_addr_o, exp);
   endtask

   task automatic end_sim;
      $display("checks %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================
   // Watchdog: the whole sequence needs well under a thousand cycles.
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      errors++;
      end_sim;
   end

   // ==========================================================
   // Main sequence
   initial begin
      repeat (8) @(posedge clk_sys_i);
      chk({power_state_o, func_rst_o, power_event_out_n_o, irq_o}, 5'h2);
      rst_n_i <= 1'b1;
      foreach (rows[i]) begin
         wb(rows[i].we, rows[i].a, rows[i].s, rows[i].d);
         if (!rows[i].we) chk(rd, rows[i].d);
      end
      // Wake from D3: internal reset, sticky enable survives.
      chk({30'h0, power_state_o}, 32'h3);
      frst_cycles = 0;
      wb(1'b1, 8'h94, 4'h1, 32'h0);
      repeat (30) @(posedge clk_sys_i);
      chk(frst_cycles, 32'd16);
      chk({30'h0, power_state_o}, 32'h0);
      wb(1'b0, 8'h94, 4'hf, 32'h0);
      chk(rd, 32'h00000100);
      // The internal reset also clears the translated base.
      wb(1'b0, 8'h98, 4'hf, 32'h0);
      chk(rd, 32'h00000000);
      // Wake edge sets status; enable lets the output assert.
      wake_evt_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      wb(1'b0, 8'h94, 4'hf, 32'h0);
      chk(rd, 32'h00008100);
      chk({31'h0, power_event_out_n_o}, 32'h0);
      wb(1'b1, 8'h94, 4'h2, 32'h00008100);
      wb(1'b0, 8'h94, 4'hf, 32'h0);
      chk(rd, 32'h00000100);
      chk({31'h0, power_event_out_n_o}, 32'h1);
      // With the enable off a new event is recorded but not signalled.
      wake_evt_i <= 1'b0;
      wb(1'b1, 8'h94, 4'h2, 32'h0);
      wake_evt_i <= 1'b1;
      repeat (6) @(posedge clk_sys_i);
      wb(1'b0, 8'h94, 4'hf, 32'h0);
      chk(rd, 32'h00008000);
      chk({31'h0, power_event_out_n_o}, 32'h1);
      // Interrupt: masked, unmasked, then cleared.
      // Status holds ignored-state, wake-reset and wake-edge events.
      wb(1'b0, 8'hb0, 4'hf, 32'h0);
      chk(rd, 32'h00000007);
      chk({31'h0, irq_o}, 32'h0);
      wb(1'b1, 8'hb4, 4'h1, 32'h4);
      @(posedge clk_sys_i);
      chk({31'h0, irq_o}, 32'h1);
      wb(1'b1, 8'hb0, 4'h1, 32'h7);
      @(posedge clk_sys_i);
      chk({31'h0, irq_o}, 32'h0);
      // Translation with the full mask, then a loader-narrowed mask.
      wb(1'b1, 8'h98, 4'hf, 32'habcde000);
      xl(32'h12345678, 32'habcde678);
      @(posedge clk_sys_i);
      setup_ld_i <= 1'b1;
      setup_ld_dat_i <= 32'h000ff00b;
      @(posedge clk_sys_i);
      setup_ld_i <= 1'b0;
      wb(1'b0, 8'h9c, 4'hf, 32'h0);
      chk(rd, 32'h800ff00a);
      xl(32'h12345678, 32'h923de678);
      end_sim;
   end
endmodule
